//--- design/buffer_changed_flag_irq_reporter.sv
// diagnostic event reporter of a two channel positioning module.
// assumes level error causes synchronous to sys_clk, host mode levels from
// the backplane, and a classic wishbone master for the record registers.
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps

// Functional notes
// - new interrupt error aborts positioning
// - sync-loss causes clear axis synchronization
// - pending error blocks start and directions
// - operating error allows jog toward range
// - switches and jobs pass while errors pend
// - any pending error reports entering event
// - partial clear re-reports entering event
// - new error: interrupt, lamp, buffer entry
// - leaving event only once all cleared
// - leaving: interrupt, lamps off after hold, no entry
// - module fault bit zero when leaving
// - no interrupts while host stopped
// - run entry re-reports still pending errors
// - no leaving interrupt if cleared in stop
// - event class 38 leave, 39 enter
// - priority 1a in run, 1c startup
// - base address at record byte 6
// - byte 8 carries the fault flags
// - byte 10 bit 3 flags watchdog trip
// - buffer entries use error class 128
// - lamps stay lit at least 3 s
// - buffer write sets changed flag per channel
module buffer_changed_flag_irq_reporter
    import buffer_changed_flag_irq_pkg::*;
#(
    parameter int unsigned HOLD_CYC = buffer_changed_flag_irq_pkg::LAMP_HOLD_CYC  // lamp hold cycles
) (
    input  wire logic        sys_clk,          // 200 mhz clock
    input  wire logic        rst,              // sync reset, high
    input  wire logic        wb_cyc_i,         // bus cycle
    input  wire logic        wb_stb_i,         // strobe
    input  wire logic        wb_we_i,          // write enable
    input  wire logic [7:0]  wb_adr_i,         // byte address
    input  wire logic [31:0] wb_dat_i,         // write data
    input  wire logic [3:0]  wb_sel_i,         // byte lanes
    output logic      [31:0] wb_dat_o,         // read data
    output logic             wb_ack_o,         // acknowledge
    input  wire logic [buffer_changed_flag_irq_pkg::NCAUSE-1:0] err_cause,  // pending causes
    input  wire logic        host_run,         // host in run
    input  wire logic        host_startup,     // host in startup
    input  wire logic        start_cmd,        // start request
    input  wire logic        dir_p_cmd,        // plus direction request
    input  wire logic        dir_m_cmd,        // minus direction request
    input  wire logic        jog_mode,         // jogging selected
    input  wire logic        range_is_plus,    // working range lies in plus
    input  wire logic        job_req,          // job or function switch
    output logic             start_ok,         // start passed on
    output logic             dir_p_ok,         // plus passed on
    output logic             dir_m_ok,         // minus passed on
    output logic             job_ok,           // job passed on
    output logic             abort_pos,        // abort positioning pulse
    output logic             clear_sync,       // drop synchronization pulse
    output logic             buffer_changed_flag_irq,         // interrupt pulse to host
    output logic             internal_fault_lamp,  // internal group lamp
    output logic             external_fault_lamp,  // external group lamp
    output logic             buf_wr,           // buffer entry strobe
    output logic      [7:0]  buf_class,        // entry error class
    output logic      [7:0]  buf_cause,        // entry causes
    output logic      [1:0]  buffer_changed_flag   // per channel
);

    // all state in one record
    typedef struct packed {
        logic [7:0]        pend;       // pending causes last cycle
        logic              active;     // host was in run or startup
        logic              host_err;   // host believes errors pend
        logic              lamp_i;     // internal lamp
        logic              lamp_e;     // external lamp
        logic [HOLD_W-1:0] hold_i;     // internal hold count
        logic [HOLD_W-1:0] hold_e;     // external hold count
        logic              irq;        // interrupt pulse
        logic              abort;      // abort pulse
        logic              clr_sync;   // sync clear pulse
        logic              bwr;        // buffer write
        logic [7:0]        bcls;       // buffer class
        logic [7:0]        bcause;     // buffer causes
        logic [1:0]        bchg;       // buffer changed
        logic [7:0]        ev;         // record byte 0
        logic [7:0]        prio;       // record byte 2
        logic [7:0]        flags;      // record byte 8
        logic              wdog;       // record byte 10 bit 3
        logic [15:0]       base;       // module base address
        logic [1:0]        chans;      // channels in use
        logic              st_ok;      // start gate
        logic              dp_ok;      // plus gate
        logic              dm_ok;      // minus gate
        logic              jb_ok;      // job gate
        logic              ack;        // bus ack
        logic [31:0]       rdata;      // bus read data
    } state_t;

    state_t s_r;    // registered state
    state_t s_nxt;  // next state

    // refuse a hold that the counter cannot carry
    if (HOLD_CYC < 1 || HOLD_CYC >= (64'd1 << HOLD_W)) begin : g_chk
        $error("HOLD_CYC out of range");
    end

    localparam logic [HOLD_W-1:0] HOLD_LD = HOLD_W'(HOLD_CYC);

    // event decode helpers
    logic       act;        // host may take interrupts
    logic       emp;        // no cause pending now
    logic [7:0] newe;       // causes that just entered
    logic [7:0] gone;       // causes that just left
    logic       resume;     // host entered run or startup
    logic       enter_ev;   // entering event now
    logic       leave_ev;   // leaving event now
    logic       blocked;    // motion commands refused
    logic       oper_only;  // only operating errors pend
    logic       bus_req;    // new bus request
    logic       wr_take;    // write committed at the ack edge

    // next state
    always_comb begin
        s_nxt     = s_r;
        act       = host_run | host_startup;
        emp       = (err_cause == '0);
        newe      = err_cause & ~s_r.pend;
        gone      = s_r.pend & ~err_cause;
        resume    = act & ~s_r.active;
        // a partial clear or fresh cause re-reports all pending
        enter_ev  = act & ~emp & ((|newe) | (|gone) | resume);
        // leaving only once the module is clean and host saw errors
        leave_ev  = act & emp & s_r.host_err;
        blocked   = ~emp;
        oper_only = ((err_cause & ~OPER_MASK) == '0);
        bus_req   = wb_cyc_i & wb_stb_i & ~s_r.ack;
        // writes land where the master sees ack, address and data still held
        wr_take   = wb_cyc_i & wb_stb_i & wb_we_i & s_r.ack;

        s_nxt.pend   = err_cause;
        s_nxt.active = act;

        // host view: while stopped a clean module owes no leaving
        if (enter_ev) begin
            s_nxt.host_err = 1'b1;
        end else if (leave_ev || emp) begin
            s_nxt.host_err = 1'b0;
        end

        // interrupt only toward a host in run or startup
        s_nxt.irq = enter_ev | leave_ev;

        // record update on each delivered event
        if (enter_ev || leave_ev) begin
            s_nxt.ev   = enter_ev ? EV_ENTER : EV_LEAVE;
            s_nxt.prio = host_run ? PRIO_RUN : PRIO_START;
            s_nxt.flags = '0;
            s_nxt.flags[F_MODULE]    = ~emp;
            s_nxt.flags[F_INTERNAL]  = |(err_cause & INT_MASK);
            s_nxt.flags[F_EXTERNAL]  = |(err_cause & ~INT_MASK);
            s_nxt.flags[F_CHANNEL]   = |(err_cause & CHAN_MASK);
            s_nxt.flags[F_AUX]       = err_cause[C_AUX_SUPPLY];
            s_nxt.flags[F_CONNECTOR] = err_cause[C_CONNECTOR];
            s_nxt.wdog = err_cause[C_WATCHDOG];
        end

        // reactions to new causes, regardless of host mode
        s_nxt.abort    = |newe;
        s_nxt.clr_sync = |(newe & SYNC_MASK);
        // leaving events never reach the buffer
        s_nxt.bwr      = |newe;
        s_nxt.bcause   = newe;
        if (|newe) begin
            s_nxt.bcls = ERR_CLASS;
        end

        // internal lamp with minimum on time
        if (|(err_cause & INT_MASK)) begin
            s_nxt.lamp_i = 1'b1;
            s_nxt.hold_i = HOLD_LD;
        end else if (s_r.hold_i != '0) begin
            s_nxt.hold_i = s_r.hold_i - 1'b1;
        end else begin
            s_nxt.lamp_i = 1'b0;
        end

        // external lamp, same scheme
        if (|(err_cause & ~INT_MASK)) begin
            s_nxt.lamp_e = 1'b1;
            s_nxt.hold_e = HOLD_LD;
        end else if (s_r.hold_e != '0) begin
            s_nxt.hold_e = s_r.hold_e - 1'b1;
        end else begin
            s_nxt.lamp_e = 1'b0;
        end

        // motion gates; jog toward range survives operating errors
        s_nxt.st_ok = start_cmd & ~blocked;
        s_nxt.dp_ok = dir_p_cmd & (~blocked |
                      (oper_only & jog_mode & range_is_plus));
        s_nxt.dm_ok = dir_m_cmd & (~blocked |
                      (oper_only & jog_mode & ~range_is_plus));
        // jobs and switches never see the error state
        s_nxt.jb_ok = job_req;

        // bus slave: one wait state, ack drops after one cycle
        s_nxt.ack   = bus_req;
        s_nxt.rdata = '0;
        if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i[7:2])
                A_REC0[7:2]: s_nxt.rdata = {HANDLER_NUM, s_r.prio,
                                            FAULT_ID, s_r.ev};
                A_REC1[7:2]: s_nxt.rdata = {s_r.base[7:0], s_r.base[15:8],
                                            IO_INPUT, 8'h00};
                A_REC2[7:2]: s_nxt.rdata = {12'h000, s_r.wdog, 3'h0,
                                            8'h00, s_r.flags};
                A_CFG[7:2]:  s_nxt.rdata = {14'h0000, s_r.chans, s_r.base};
                A_STAT[7:2]: s_nxt.rdata = {21'h000000, s_r.host_err,
                                            s_r.bchg, s_r.pend};
                default:     s_nxt.rdata = '0;   // unmapped reads zero
            endcase
        end

        // configuration writes by lane
        if (wr_take && wb_adr_i[7:2] == A_CFG[7:2]) begin
            if (wb_sel_i[0]) begin
                s_nxt.base[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                s_nxt.base[15:8] = wb_dat_i[15:8];
            end
            if (wb_sel_i[2]) begin
                s_nxt.chans = wb_dat_i[17:16];
            end
        end

        // buffer changed: software clears, a new entry wins
        if (wr_take && wb_adr_i[7:2] == A_BUFACK[7:2] && wb_sel_i[0]) begin
            s_nxt.bchg = s_r.bchg & ~wb_dat_i[1:0];
        end
        if (|newe) begin
            s_nxt.bchg = s_nxt.bchg | s_r.chans;
        end
    end

    // single state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r       <= '0;
            s_r.base  <= BASE_RST;
            s_r.chans <= CHAN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state
    assign wb_dat_o            = s_r.rdata;
    assign wb_ack_o            = s_r.ack;
    assign start_ok            = s_r.st_ok;
    assign dir_p_ok            = s_r.dp_ok;
    assign dir_m_ok            = s_r.dm_ok;
    assign job_ok              = s_r.jb_ok;
    assign abort_pos           = s_r.abort;
    assign clear_sync          = s_r.clr_sync;
    assign buffer_changed_flag_irq            = s_r.irq;
    assign internal_fault_lamp = s_r.lamp_i;
    assign external_fault_lamp = s_r.lamp_e;
    assign buf_wr              = s_r.bwr;
    assign buf_class           = s_r.bcls;
    assign buf_cause           = s_r.bcause;
    assign buffer_changed_flag = s_r.bchg;

    // checks on the event engine
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    irq_gated_a: assert property (buffer_changed_flag_irq |-> $past(host_run | host_startup))
        else $error("interrupt while host stopped");

    abort_new_a: assert property (|(err_cause & ~s_r.pend) |=> abort_pos)
        else $error("new error did not abort");

    sync_clear_a: assert property (|(err_cause & SYNC_MASK & ~s_r.pend)
        |=> clear_sync)
        else $error("sync not cleared");

    start_block_a: assert property ((err_cause != '0) && start_cmd |=> !start_ok)
        else $error("start passed with error");

    jog_toward_a: assert property ((err_cause != '0)
        && ((err_cause & ~OPER_MASK) == '0) && jog_mode && range_is_plus
        && dir_p_cmd |=> dir_p_ok)
        else $error("jog toward range refused");

    leave_rec_a: assert property (buffer_changed_flag_irq && s_r.ev == EV_LEAVE
        |-> !s_r.flags[F_MODULE] && !buf_wr)
        else $error("bad leaving record");

    prio_run_a: assert property (buffer_changed_flag_irq && $past(host_run)
        |-> s_r.prio == PRIO_RUN)
        else $error("wrong run priority");

    buf_flag_a: assert property (buf_wr |-> (buffer_changed_flag & s_r.chans)
        == s_r.chans && buf_class == ERR_CLASS)
        else $error("buffer flag or class wrong");

    lamp_hold_a: assert property ($fell(internal_fault_lamp)
        |-> $past(s_r.hold_i) == '0)
        else $error("lamp dropped early");

    enter_again_a: assert property ((host_run | host_startup) && s_r.active
        && (err_cause != '0) && (|(s_r.pend & ~err_cause))
        |=> buffer_changed_flag_irq && s_r.ev == EV_ENTER)
        else $error("partial clear not reported");

    // lamp, event record, gate and host mode checks; run entry is where stale views bite
    lamp_ext_hold_a: assert property ($fell(external_fault_lamp)
        |-> $past(s_r.hold_e) == '0)
        else $error("external lamp dropped early");

    lamp_int_on_a: assert property (|(err_cause & INT_MASK)
        |=> internal_fault_lamp)
        else $error("internal lamp not lit");

    lamp_ext_on_a: assert property (|(err_cause & ~INT_MASK)
        |=> external_fault_lamp)
        else $error("external lamp not lit");

    leave_clean_a: assert property (buffer_changed_flag_irq && s_r.ev == EV_LEAVE
        |-> s_r.pend == '0)
        else $error("leaving with errors pending");

    enter_class_a: assert property (buffer_changed_flag_irq && s_r.pend != '0
        |-> s_r.ev == EV_ENTER)
        else $error("pending errors not reported entering");

    run_reenter_a: assert property ((host_run || host_startup) && !s_r.active
        && (err_cause != '0)
        |=> buffer_changed_flag_irq && s_r.ev == EV_ENTER)
        else $error("run entry did not re-report");

    stop_quiet_a: assert property ((host_run || host_startup) && !s_r.active
        && (s_r.pend == '0) && (err_cause == '0)
        |=> !buffer_changed_flag_irq)
        else $error("leaving raised after clean stop");

    job_pass_a: assert property (job_req |=> job_ok)
        else $error("job held back");

endmodule

//--- design/buffer_changed_flag_irq_pkg.sv
// constants of the diagnostic interrupt reporter: record codes, cause bits,
// register offsets, reset values and lamp timing.
// assumes a 200 MHz system clock and a 32-bit classic wishbone register bus.
package buffer_changed_flag_irq_pkg;

    // cause vector layout, one level per error source
    localparam int NCAUSE               = 8;
    localparam int C_CONNECTOR          = 0;    // front connector missing
    localparam int C_AUX_SUPPLY         = 1;    // encoder auxiliary supply missing
    localparam int C_ZERO_MARK          = 2;    // zero marker error
    localparam int C_CABLE              = 3;    // encoder cable fault
    localparam int C_RANGE              = 4;    // travel range exceeded (operating)
    localparam int C_SET_ACTUAL         = 5;    // set actual value failed (operating)
    localparam int C_INTERNAL           = 6;    // internal module fault
    localparam int C_WATCHDOG           = 7;    // supervision tripped
    localparam logic [7:0] SYNC_MASK    = 8'h3f; // causes that drop synchronization
    localparam logic [7:0] OPER_MASK    = 8'h30; // operating errors
    localparam logic [7:0] INT_MASK     = 8'hc0; // internal lamp group
    localparam logic [7:0] CHAN_MASK    = 8'h3c; // channel related causes

    // diagnostic record codes
    localparam logic [7:0] EV_LEAVE     = 8'h38;
    localparam logic [7:0] EV_ENTER     = 8'h39;
    localparam logic [7:0] FAULT_ID     = 8'h42;
    localparam logic [7:0] PRIO_RUN     = 8'h1a;
    localparam logic [7:0] PRIO_START   = 8'h1c;
    localparam logic [7:0] HANDLER_NUM  = 8'h52;
    localparam logic [7:0] IO_INPUT     = 8'h54;
    localparam logic [7:0] ERR_CLASS    = 8'h80; // class 128
    localparam int F_MODULE             = 0;    // record byte 8 bits
    localparam int F_INTERNAL           = 1;
    localparam int F_EXTERNAL           = 2;
    localparam int F_CHANNEL            = 3;
    localparam int F_AUX                = 4;
    localparam int F_CONNECTOR          = 5;
    localparam int F_WATCHDOG           = 3;    // record byte 10 bit

    // register word offsets (byte addresses)
    localparam logic [7:0] A_REC0       = 8'h00; // bytes 0..3
    localparam logic [7:0] A_REC1       = 8'h04; // bytes 4..7
    localparam logic [7:0] A_REC2       = 8'h08; // bytes 8..11
    localparam logic [7:0] A_CFG        = 8'h0c; // base address, channels in use
    localparam logic [7:0] A_STAT       = 8'h10; // pending causes, flags
    localparam logic [7:0] A_BUFACK     = 8'h14; // buffer read done, per channel
    localparam logic [15:0] BASE_RST    = 16'h0000;
    localparam logic [1:0] CHAN_RST     = 2'h3;

    // lamp minimum on time
    localparam int HOLD_W               = 30;
    localparam int LAMP_HOLD_MS         = 3000;
    localparam int CLK_KHZ              = 200000;
    localparam int LAMP_HOLD_CYC        = LAMP_HOLD_MS * CLK_KHZ;

endpackage

//--- test/host_cpu_model.sv
// host controller model on the backplane: holds the mode levels and
// takes the diagnostic interrupts of the module.
// assumes buffer_changed_flag_irq is a one-cycle pulse synchronous to sys_clk.
`timescale 1ns/1ps
module host_cpu_model (
    input  wire logic sys_clk,      // system clock
    input  wire logic rst,          // sync reset, high
    input  wire logic buffer_changed_flag_irq,     // interrupt pulse from module
    output logic      host_run,     // run mode level
    output logic      host_startup, // startup mode level
    output int        irq_seen,     // interrupts taken while active
    output int        irq_lost      // interrupts arriving while stopped
);
    // host starts out stopped, as after power up
    initial begin
        host_run = 1'b0;
        host_startup = 1'b0;
    end

    // mode change right after an edge, like any other backplane level
    task automatic set_mode(input logic run, input logic su);
        @(posedge sys_clk);
        host_run <= run;
        host_startup <= su;
    endtask

    // interrupt intake; a stopped host counts what should never arrive
    always @(posedge sys_clk) begin
        if (rst) begin
            irq_seen <= 0;
            irq_lost <= 0;
        end else if (buffer_changed_flag_irq === 1'b1) begin
            if (host_run | host_startup) begin
                irq_seen <= irq_seen + 1;
            end else begin
                irq_lost <= irq_lost + 1;
            end
        end
    end
endmodule

//--- test/diagnostic_interrupt_reporter_tb_top.sv
// testbench of the diagnostic interrupt reporter: register reads over
// wishbone, error causes stepped in and out, host mode changes.
// assumes the host model of host_cpu_model.sv and a short lamp hold.
`timescale 1ns/1ps
module diagnostic_interrupt_reporter_tb_top;
    import buffer_changed_flag_irq_pkg::*;
    localparam int HOLD = 20;       // short lamp hold for simulation
    logic sys_clk = 1'b0;           // 200 mhz
    logic rst = 1'b1;               // held for 16 cycles
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [NCAUSE-1:0] err_cause = '0;
    logic host_run, host_startup;
    logic start_cmd = 1'b0, dir_p_cmd = 1'b0, dir_m_cmd = 1'b0;
    logic jog_mode = 1'b0, range_is_plus = 1'b0, job_req = 1'b0;
    logic start_ok, dir_p_ok, dir_m_ok, job_ok, abort_pos, clear_sync;
    logic buffer_changed_flag_irq, internal_fault_lamp, external_fault_lamp, buf_wr;
    logic [7:0] buf_class, buf_cause;
    logic [1:0] buffer_changed_flag;
    int irq_seen, irq_lost;
    int bad_count = 0, n_compared = 0;
    int buf_n = 0, abort_n = 0, sync_n = 0; // pulse counts
    logic [7:0] last_cause, last_class;     // latched at each entry
    logic [31:0] q;

    buffer_changed_flag_irq_reporter #(.HOLD_CYC(HOLD)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .err_cause(err_cause),
        .host_run(host_run), .host_startup(host_startup), .start_cmd(start_cmd),
        .dir_p_cmd(dir_p_cmd), .dir_m_cmd(dir_m_cmd), .jog_mode(jog_mode),
        .range_is_plus(range_is_plus), .job_req(job_req), .start_ok(start_ok),
        .dir_p_ok(dir_p_ok), .dir_m_ok(dir_m_ok), .job_ok(job_ok), .abort_pos(abort_pos),
        .clear_sync(clear_sync), .buffer_changed_flag_irq(buffer_changed_flag_irq),
        .internal_fault_lamp(internal_fault_lamp),
        .external_fault_lamp(external_fault_lamp),
        .buf_wr(buf_wr), .buf_class(buf_class), .buf_cause(buf_cause),
        .buffer_changed_flag(buffer_changed_flag)
    );
    host_cpu_model host_u (
        .sys_clk(sys_clk), .rst(rst), .buffer_changed_flag_irq(buffer_changed_flag_irq), .host_run(host_run),
        .host_startup(host_startup), .irq_seen(irq_seen), .irq_lost(irq_lost)
    );

    always #2.5 sys_clk = ~sys_clk;

    // pulse counting; one count per high cycle shows pulse width too
    always @(posedge sys_clk) begin
        if (!rst) begin
            buf_n += (buf_wr === 1'b1);
            abort_n += (abort_pos === 1'b1);
            sync_n += (clear_sync === 1'b1);
            if (buf_wr === 1'b1) begin
                last_cause = buf_cause;
                last_class = buf_class;
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; called right after a rising edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        check(q & m, e);
    endtask

    // step the cause vector and compare interrupt, entry and sync counts
    task automatic ev(input logic [7:0] v, input int di, input int db, input int ds);
        int i0, b0, a0, s0;
        i0 = irq_seen;
        b0 = buf_n;
        a0 = abort_n;
        s0 = sync_n;
        err_cause <= v;
        repeat (4) @(posedge sys_clk);
        check(irq_seen - i0, di);
        check(buf_n - b0, db);
        check(abort_n - a0, db);
        check(sync_n - s0, ds);
    endtask

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog, far beyond the roughly 150 cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        host_u.set_mode(1'b1, 1'b0);
        start_cmd <= 1'b1;
        job_req <= 1'b1;
        @(posedge sys_clk);
        rd(A_CFG, 32'hffff_ffff, 32'h0003_0000);
        rd(8'h3c, 32'hffff_ffff, 32'h0);
        wb(1'b1, A_CFG, 32'h0003_1234, 4'hf);
        rd(A_REC1, 32'hffff_ffff, 32'h3412_5400);
        check(start_ok, 1'b1);
        $display("registers done");
        ev(8'h01, 1, 1, 1);
        check(last_cause, 8'h01);
        check(last_class, ERR_CLASS);
        check({internal_fault_lamp, external_fault_lamp}, 2'b01);
        check(buffer_changed_flag, 2'h3);
        rd(A_REC0, 32'hffff_ffff, 32'h521a_4239);
        rd(A_REC2, 32'h000f_0fff, 32'h25);
        rd(A_STAT, 32'h0000_03ff, 32'h301);
        check({start_ok, job_ok}, 2'b01);
        wb(1'b1, A_BUFACK, 32'h1, 4'h1);
        check(buffer_changed_flag, 2'h2);
        rd(A_STAT, 32'h0000_0300, 32'h200);
        $display("entering done");
        ev(8'h11, 1, 1, 1);
        ev(8'h10, 1, 0, 0);
        rd(A_REC0, 32'h0000_00ff, 32'h39);
        jog_mode <= 1'b1;
        range_is_plus <= 1'b1;
        dir_p_cmd <= 1'b1;
        dir_m_cmd <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({dir_p_ok, dir_m_ok, start_ok}, 3'b100);
        range_is_plus <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check({dir_p_ok, dir_m_ok}, 2'b01);
        $display("partial clear done");
        ev(8'h00, 1, 0, 0);
        rd(A_REC0, 32'h0000_00ff, 32'h38);
        rd(A_REC2, 32'h0000_003f, 32'h0);
        check(external_fault_lamp, 1'b1);
        check({dir_m_ok, start_ok}, 2'b11);
        repeat (HOLD + 4) @(posedge sys_clk);
        check(external_fault_lamp, 1'b0);
        $display("leaving done");
        host_u.set_mode(1'b0, 1'b0);
        ev(8'h80, 0, 1, 0);
        check(internal_fault_lamp, 1'b1);
        host_u.set_mode(1'b0, 1'b1);
        ev(8'h80, 1, 0, 0);
        rd(A_REC0, 32'h00ff_00ff, 32'h001c_0039);
        rd(A_REC2, 32'h0008_00ff, 32'h0008_0003);
        host_u.set_mode(1'b0, 1'b0);
        ev(8'h00, 0, 0, 0);
        host_u.set_mode(1'b1, 1'b0);
        ev(8'h00, 0, 0, 0);
        repeat (HOLD + 4) @(posedge sys_clk);
        check(internal_fault_lamp, 1'b0);
        check(irq_lost, 0);
        $display("host stop done");
        report_and_stop();
    end
endmodule
